// ===== design/placeholder_none.sv
// Intentionally empty compilation unit.

// ===== design/srs_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/10ps
`default_nettype none

module srs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0] wr_ptr_reg, wr_ptr_next;
    logic [PW-1:0] rd_ptr_reg, rd_ptr_next;
    logic [CW-1:0] count_reg, count_next;
    logic push;
    logic pop;

    // ==========================================================
    // Pointer and occupancy update
    // ==========================================================
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_ptr_next = push ? PW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
        rd_ptr_next = pop ? PW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
        count_next = count_reg;
        if (push && !pop) begin
            count_next = CW'(count_reg + 1'b1);
        end else if (pop && !push) begin
            count_next = CW'(count_reg - 1'b1);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
        end
    end

    // Storage needs no reset; entries are only read once written.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    assign in_ready = (count_reg != CW'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem_reg[rd_ptr_reg];
    assign count = count_reg;

endmodule // srs_fifo

`default_nettype wire

// ===== design/srs_pkg.sv
// Shared types and constants of the stream register slice.
package srs_pkg;

    // ==========================================================
    // Payload layout
    // ==========================================================
    localparam int DATA_W = 64;
    localparam int KEEP_W = DATA_W / 8;

    typedef struct packed {
        logic [DATA_W-1:0] tdata;
        logic [KEEP_W-1:0] tkeep;
        logic tlast;
    } srs_beat_t;

    localparam int BEAT_W = $bits(srs_beat_t);

    // ==========================================================
    // Modes
    // ==========================================================
    typedef enum logic [2:0] {
        SRS_MODE_FULL,
        SRS_MODE_LIGHT,
        SRS_MODE_XING,
        SRS_MODE_TDM,
        SRS_MODE_BYPASS
    } srs_mode_t;

    // ==========================================================
    // Buffer sizing and occupancy limits
    // ==========================================================
    localparam int FIFO_DEPTH = 4;
    localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_LIMIT = 3'h2;
    localparam logic [CNT_W-1:0] LIGHT_LIMIT = 3'h1;
    localparam logic [CNT_W-1:0] XING_LIMIT = 3'h4;

    // Latencies in clock cycles, valid in to first valid out.
    localparam int LAT_FULL = 1;
    localparam int LAT_LIGHT = 1;
    localparam int LAT_XING = 3;
    localparam int LAT_BYPASS = 0;

endpackage

// ===== design/srs_slice.sv
// Configurable stream register slice with five pipeline modes.
`timescale 1ns/10ps
`default_nettype none

// Function
// - Full mode adds one clock of latency and never stalls back-to-back while downstream is ready.
// - Light mode adds one clock latency and one bubble after each accept.
// - Die-region crossing mode delivers three clocks later without stalls while downstream is ready.
// - Time-multiplexed crossing mode has three clocks latency, no stalls while downstream is ready.
// - Bypass mode wires upstream straight to the downstream port.
// - Latency counts from upstream valid to first downstream valid.
// - Back-to-back delay counts clocks upstream ready stays low after accept.
// - Full mode is a two-entry buffer tolerating throttling on both sides.
module srs_slice (
    input wire logic clk,
    input wire logic resetn,
    input wire srs_pkg::srs_mode_t mode,
    input wire logic up_tvalid,
    output logic up_tready,
    input wire srs_pkg::srs_beat_t up_beat,
    output logic dn_tvalid,
    input wire logic dn_tready,
    output srs_pkg::srs_beat_t dn_beat
);

    // ==========================================================
    // Mode decode
    // ==========================================================
    logic piped;
    logic bypass;
    logic [srs_pkg::CNT_W-1:0] fill_limit;

    always_comb begin
        piped = 1'b0;
        bypass = 1'b0;
        fill_limit = srs_pkg::FULL_LIMIT;
        case (mode)
            srs_pkg::SRS_MODE_FULL: begin
                fill_limit = srs_pkg::FULL_LIMIT;
            end
            srs_pkg::SRS_MODE_LIGHT: begin
                fill_limit = srs_pkg::LIGHT_LIMIT;
            end
            srs_pkg::SRS_MODE_XING, srs_pkg::SRS_MODE_TDM: begin
                piped = 1'b1;
                fill_limit = srs_pkg::XING_LIMIT;
            end
            srs_pkg::SRS_MODE_BYPASS: begin
                bypass = 1'b1;
            end
            default: begin
                bypass = 1'b1;
            end
        endcase
    end

    // ==========================================================
    // Crossing pipeline stages
    // ==========================================================
    // The two stages move every cycle without back-pressure, which
    // keeps them free of a long ready path. The buffer behind them
    // reserves room for both, so nothing in flight can be dropped.
    logic st1_valid_reg, st1_valid_next;
    logic st2_valid_reg, st2_valid_next;
    srs_pkg::srs_beat_t st1_beat_reg, st1_beat_next;
    srs_pkg::srs_beat_t st2_beat_reg, st2_beat_next;
    logic up_fire;
    logic [srs_pkg::CNT_W-1:0] fifo_count;
    logic [srs_pkg::CNT_W-1:0] in_flight;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    srs_pkg::srs_beat_t fifo_in_beat;
    srs_pkg::srs_beat_t fifo_out_beat;

    always_comb begin
        st1_valid_next = piped && up_fire;
        st1_beat_next = up_fire ? up_beat : st1_beat_reg;
        st2_valid_next = st1_valid_reg;
        st2_beat_next = st1_valid_reg ? st1_beat_reg : st2_beat_reg;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st1_valid_reg <= 1'b0;
            st2_valid_reg <= 1'b0;
            st1_beat_reg <= '0;
            st2_beat_reg <= '0;
        end else begin
            st1_valid_reg <= st1_valid_next;
            st2_valid_reg <= st2_valid_next;
            st1_beat_reg <= st1_beat_next;
            st2_beat_reg <= st2_beat_next;
        end
    end

    // ==========================================================
    // Upstream handshake and buffer feed
    // ==========================================================
    always_comb begin
        in_flight = srs_pkg::CNT_W'(fifo_count + st1_valid_reg
            + st2_valid_reg);
        if (bypass) begin
            up_tready = dn_tready;
        end else if (piped) begin
            up_tready = in_flight < fill_limit;
        end else begin
            up_tready = fifo_in_ready && (fifo_count < fill_limit);
        end
        up_fire = up_tvalid && up_tready;
        if (piped) begin
            fifo_in_valid = st2_valid_reg;
            fifo_in_beat = st2_beat_reg;
        end else begin
            fifo_in_valid = up_tvalid && up_tready && !bypass;
            fifo_in_beat = up_beat;
        end
    end

    srs_fifo #(
        .WIDTH(srs_pkg::BEAT_W),
        .DEPTH(srs_pkg::FIFO_DEPTH)
    ) srs_fifo_inst (
        .clk(clk),
        .resetn(resetn),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_beat),
        .out_valid(fifo_out_valid),
        .out_ready(dn_tready && !bypass),
        .out_data(fifo_out_beat),
        .count(fifo_count)
    );

    // ==========================================================
    // Downstream port
    // ==========================================================
    // In bypass the port is a plain wire, so its data is not
    // registered; all other modes drive it from buffer storage.
    always_comb begin
        if (bypass) begin
            dn_tvalid = up_tvalid;
            dn_beat = up_beat;
        end else begin
            dn_tvalid = fifo_out_valid;
            dn_beat = fifo_out_beat;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    logic is_full;
    logic is_light;
    logic is_xing;
    logic is_tdm;
    logic pipe_idle;
    assign is_full = (mode == srs_pkg::SRS_MODE_FULL);
    assign is_light = (mode == srs_pkg::SRS_MODE_LIGHT);
    assign is_xing = (mode == srs_pkg::SRS_MODE_XING);
    assign is_tdm = (mode == srs_pkg::SRS_MODE_TDM);
    assign pipe_idle = !st1_valid_reg && !st2_valid_reg
        && (fifo_count == '0);

    full_latency_a: assert property (
        $stable(mode) && is_full && up_fire && !dn_tvalid
        |=> dn_tvalid && dn_beat == $past(up_beat))
        else $error("Full mode did not present the beat one clock later.");

    full_no_stall_a: assert property (
        is_full && up_fire && dn_tready |=> up_tready)
        else $error("Full mode stalled a back-to-back transfer.");

    full_two_entry_a: assert property (
        is_full |-> fifo_count <= srs_pkg::FULL_LIMIT)
        else $error("Full mode held more than two transfers.");

    light_bubble_a: assert property (
        is_light && up_fire |=> !up_tready && dn_tvalid)
        else $error("Light mode skipped its bubble or its output.");

    xing_latency_a: assert property (
        $stable(mode) && is_xing && up_fire && pipe_idle
        |=> !dn_tvalid ##1 !dn_tvalid ##1 dn_tvalid)
        else $error("Crossing mode latency is not three clocks.");

    tdm_latency_a: assert property (
        $stable(mode) && is_tdm && up_fire && pipe_idle
        |=> !dn_tvalid ##1 !dn_tvalid ##1 dn_tvalid)
        else $error("Multiplexed mode latency is not three clocks.");

    pipe_no_stall_a: assert property (
        (is_xing || is_tdm) && fifo_count <= 3'h1 |-> up_tready)
        else $error("Crossing mode stalled while its buffer was drained.");

    bypass_wire_a: assert property (
        bypass |-> dn_tvalid == up_tvalid && up_tready == dn_tready
        && dn_beat == up_beat)
        else $error("Bypass mode is not a straight connection.");

    dn_hold_a: assert property (
        !bypass && dn_tvalid && !dn_tready |=> dn_tvalid
        && $stable(dn_beat))
        else $error("Downstream beat changed before it was taken.");

    full_burst_c: cover property (
        is_full && up_fire ##1 up_fire ##1 up_fire);
    light_pair_c: cover property (
        is_light && up_fire ##2 up_fire);
    xing_fill_c: cover property (
        is_xing && !up_tready);
    tdm_stream_c: cover property (
        is_tdm && up_fire ##1 up_fire ##1 dn_tvalid && dn_tready);

endmodule // srs_slice

`default_nettype wire

// ===== sim/srs_sink_model.sv
// Downstream stream sink model that records every beat it takes.
`timescale 1ns/10ps
`default_nettype none

module srs_sink_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic throttle,
    input wire logic dn_tvalid,
    output var logic dn_tready,
    input wire srs_pkg::srs_beat_t dn_beat
);
    srs_pkg::srs_beat_t got[$];

    // A sink may drop ready at any time, so throttling toggles it.
    always @(posedge clk) begin
        if (!resetn) begin
            dn_tready <= 1'b0;
        end else begin
            dn_tready <= throttle ? ~dn_tready : 1'b1;
        end
        if (resetn && dn_tvalid && dn_tready) begin
            got.push_back(dn_beat);
        end
    end
endmodule // srs_sink_model

`default_nettype wire

// ===== sim/srs_slice_tb.sv
// Self-checking testbench of the stream register slice.
`timescale 1ns/10ps
`default_nettype none

module srs_slice_tb;
    localparam logic [63:0] TAG = 64'hA500_0000_0000_0000;
    logic clk;
    logic resetn;
    srs_pkg::srs_mode_t mode;
    logic up_tvalid;
    logic up_tready;
    srs_pkg::srs_beat_t up_beat;
    logic dn_tvalid;
    logic dn_tready;
    srs_pkg::srs_beat_t dn_beat;
    logic throttle;
    int n_errors;
    int n_tests;
    srs_pkg::srs_mode_t modes [5] = '{srs_pkg::SRS_MODE_FULL,
        srs_pkg::SRS_MODE_LIGHT, srs_pkg::SRS_MODE_XING,
        srs_pkg::SRS_MODE_TDM, srs_pkg::SRS_MODE_BYPASS};
    int lats [5] = '{srs_pkg::LAT_FULL, srs_pkg::LAT_LIGHT,
        srs_pkg::LAT_XING, srs_pkg::LAT_XING, srs_pkg::LAT_BYPASS};

    srs_slice srs_slice_inst (.clk(clk), .resetn(resetn), .mode(mode),
        .up_tvalid(up_tvalid), .up_tready(up_tready), .up_beat(up_beat),
        .dn_tvalid(dn_tvalid), .dn_tready(dn_tready), .dn_beat(dn_beat));
    srs_sink_model srs_sink_model_inst (.clk(clk), .resetn(resetn),
        .throttle(throttle), .dn_tvalid(dn_tvalid),
        .dn_tready(dn_tready), .dn_beat(dn_beat));

    // Multiplexed mode runs on this one clock, so any double-rate copy
    // would come from the same source with no phase shift.
    always #4 clk = ~clk;

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Mode may only change while reset is held.
    task automatic do_reset(input srs_pkg::srs_mode_t m, input logic thr);
        @(posedge clk);
        resetn <= 1'b0;
        mode <= m;
        throttle <= thr;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        srs_sink_model_inst.got.delete();
    endtask

    // Holds one beat until taken; counts cycles ready was low meanwhile.
    task automatic send(input int i, input int n, output int gaps);
        logic rdy;
        up_tvalid <= 1'b1;
        up_beat <= '{tdata: TAG | 64'(i), tkeep: 8'hFF, tlast: i == n - 1};
        gaps = 0;
        for (int k = 0; k < 40; k++) begin
            @(negedge clk);
            rdy = up_tready;
            gaps += rdy ? 0 : 1;
            @(posedge clk);
            if (rdy) break;
        end
    endtask

    task automatic drain_check(input int n);
        srs_pkg::srs_beat_t b;
        int sz;
        for (int k = 0; k < 80; k++) begin
            if (srs_sink_model_inst.got.size() >= n) break;
            @(posedge clk);
        end
        sz = srs_sink_model_inst.got.size();
        check("beats", 64'(sz), 64'(n));
        for (int i = 0; i < n && i < sz; i++) begin
            b = srs_sink_model_inst.got[i];
            check("data", b.tdata, TAG | 64'(i));
            check("last", 64'(b.tlast), 64'(i == n - 1));
            check("keep", 64'(b.tkeep), 64'hFF);
        end
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic test_latency();
        logic rdy;
        logic pend;
        int lat;
        for (int m = 0; m < 5; m++) begin
            do_reset(modes[m], 1'b0);
            up_tvalid <= 1'b1;
            up_beat <= '{tdata: TAG, tkeep: 8'hFF, tlast: 1'b1};
            pend = 1'b1;
            lat = -1;
            for (int k = 0; k < 12 && lat < 0; k++) begin
                @(negedge clk);
                rdy = up_tready & pend;
                if (dn_tvalid) lat = k;
                @(posedge clk);
                if (rdy) begin
                    up_tvalid <= 1'b0;
                    pend = 1'b0;
                end
            end
            check("latency", 64'(lat), 64'(lats[m]));
            drain_check(1);
        end
        $display("test latency done");
    endtask

    task automatic test_back_to_back();
        int g;
        int tot;
        for (int m = 0; m < 5; m++) begin
            do_reset(modes[m], 1'b0);
            tot = 0;
            for (int i = 0; i < 6; i++) begin
                send(i, 6, g);
                tot += g;
            end
            up_tvalid <= 1'b0;
            drain_check(6);
            check("gaps", 64'(tot), (m == 1) ? 64'h5 : '0);
        end
        $display("test back to back done");
    endtask

    task automatic test_throttle();
        int g;
        for (int m = 0; m < 4; m++) begin
            do_reset(modes[m], 1'b1);
            for (int i = 0; i < 8; i++) begin
                send(i, 8, g);
            end
            up_tvalid <= 1'b0;
            drain_check(8);
        end
        $display("test throttle done");
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end

    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        mode = srs_pkg::SRS_MODE_FULL;
        up_tvalid = 1'b0;
        up_beat = '0;
        throttle = 1'b0;
        n_errors = 0;
        n_tests = 0;
        test_latency();
        test_back_to_back();
        test_throttle();
        report_and_stop();
    end
endmodule // srs_slice_tb

`default_nettype wire
